// >>> inc/qcsdc_params.svh
// qcsdc_params.svh: register map, field positions, reset values for the select control.
// assumes a 32-bit Avalon-MM slave with byte addresses and one select line.
`ifndef QCSDC_PARAMS_SVH
`define QCSDC_PARAMS_SVH

`define QCSDC_OFF_CTRL 4'h0
`define QCSDC_OFF_MODE 4'h4
`define QCSDC_OFF_TXD 4'h8
`define QCSDC_OFF_STAT 4'hC

`define QCSDC_CTRL_FINAL 0
`define QCSDC_MODE_HOLD_LO 0
`define QCSDC_MODE_HOLD_HI 1
`define QCSDC_MODE_DLY_LO 8
`define QCSDC_MODE_DLY_HI 15
`define QCSDC_STAT_EMPTY 0
`define QCSDC_STAT_SEL 1
`define QCSDC_STAT_BUSY 2
`define QCSDC_STAT_FINAL 3

`define QCSDC_RST_HOLD 2'h0
`define QCSDC_RST_DLY 8'h00
`define QCSDC_HOLD_AUTO 2'h0
`define QCSDC_HOLD_KEEP 2'h1
`define QCSDC_HOLD_EACH 2'h2

`endif

// >>> inc/qcsdc_pkg.sv
// qcsdc_pkg: types shared by the select control files.
// assumes qcsdc_params.svh supplies the numeric constants.
package qcsdc_pkg;
   typedef enum logic [2:0] {
      QCSDC_IDLE, QCSDC_SHIFT, QCSDC_GAP, QCSDC_HOLDSEL, QCSDC_DESEL
   } qcsdc_state_t;
endpackage : qcsdc_pkg

// >>> inc/qcsdc_stream_if.sv
// qcsdc_stream_if: valid/ready word stream between the select control and its buffer.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface qcsdc_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : qcsdc_stream_if

// >>> src/qcsdc_buf.sv
// qcsdc_buf: small first-in first-out buffer for words waiting to be shifted.
// assumes synchronous active-high reset and one clock.
`timescale 1ns/10ps
module qcsdc_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // streams
   qcsdc_stream_if.snk fill,
   qcsdc_stream_if.src drain
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
   logic [AW:0] count_r, count_nxt;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : bump

   assign fill.ready = (count_r != (AW + 1)'(DEPTH));
   assign drain.valid = (count_r != '0);
   assign drain.data = mem[rdPtr_r];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   always_comb begin
      wrPtr_nxt = push ? bump(wrPtr_r) : wrPtr_r;
      rdPtr_nxt = pop ? bump(rdPtr_r) : rdPtr_r;
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = (AW + 1)'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = (AW + 1)'(count_r - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         count_r <= count_nxt;
      end
      if (push) begin
         mem[wrPtr_r] <= fill.data;
      end
   end
endmodule : qcsdc_buf

// >>> src/qcsdc_top.sv
// qcsdc_top: serial flash master transmit path with select hold control.
// assumes an Avalon-MM master on clk and a link clock input from outside this domain.
//
// Overview of operation
// R1: the holding-empty flag shows that a word has left the holding buffer for the shifter; here it is high while the buffer has a free entry.
// R2: a word queued before the current transfer ends keeps the select low across both; here in hold modes 0 and 1, while mode 2 releases after each word.
// R3: the flash select output is active low, low selects and high releases.
// R4: in hold mode 1 the select stays low with no new word until a final command ends it.
// R5: the host writes the final command with or after the last word to get a release.
// R6: a DMA engine reloads the holding buffer as soon as the empty flag requests it.
// R7: in hold mode 0 the select release depends only on whether a word was reloaded in time.
// R8: in hold mode 2 the select is released after every word.
// R9: a programmable gap follows each word, zero giving the shortest reload window.
// R10: in hold mode 0 an empty buffer at the end of a word releases the select after the gap.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "qcsdc_params.svh"
module qcsdc_top
   import qcsdc_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // link clock from outside
   input wire logic linkClk,
   // flash pins
   output logic serialFlashSelectN,
   output logic flashClk,
   output logic flashDataOut,
   // dma request
   output logic holdingEmptyFlag
);
   localparam int CW = $clog2(WIDTH + 1);

   qcsdc_stream_if #(.WIDTH(WIDTH)) toBuf ();
   qcsdc_stream_if #(.WIDTH(WIDTH)) fromBuf ();

   qcsdc_buf #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_buf (
      .clk(clk),
      .srst(srst),
      .fill(toBuf.snk),
      .drain(fromBuf.src)
   );

   function automatic logic regHit(input logic [3:0] a, input logic [3:0] off);
      regHit = (a == off);
   endfunction : regHit

   qcsdc_state_t state_r, state_nxt;
   logic [1:0] holdMode_r, holdMode_nxt;
   logic [7:0] gapDelay_r, gapDelay_nxt, gapCnt_r, gapCnt_nxt;
   logic finalReq_r, finalReq_nxt;
   logic [WIDTH-1:0] shift_r, shift_nxt;
   logic [CW-1:0] bitCnt_r, bitCnt_nxt;
   logic selN_r, selN_nxt, sck_r, sck_nxt, dout_r, dout_nxt;
   logic wait_r, wait_nxt, empty_r, empty_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic sync1_r, sync2_r, sync3_r;
   logic linkRise, linkFall, acc, wrCommit, finalClr, loadNow;

   assign linkRise = sync2_r && !sync3_r;
   assign linkFall = !sync2_r && sync3_r;
   assign acc = (read || write) && wait_r;
   assign wrCommit = write && !wait_r;

   // tx write only commits once buffer space was seen, stalling the master otherwise
   assign toBuf.valid = wrCommit && regHit(address, `QCSDC_OFF_TXD);
   assign toBuf.data = writedata[WIDTH-1:0];
   assign fromBuf.ready = loadNow;

   // bus slave: waitrequest drops for one cycle per request
   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      holdMode_nxt = holdMode_r;
      gapDelay_nxt = gapDelay_r;
      if (acc && !(write && regHit(address, `QCSDC_OFF_TXD) && !toBuf.ready)) begin
         wait_nxt = 1'b0;
      end
      if (acc && read) begin
         rdata_nxt = '0;
         if (regHit(address, `QCSDC_OFF_MODE)) begin
            rdata_nxt[`QCSDC_MODE_HOLD_HI:`QCSDC_MODE_HOLD_LO] = holdMode_r;
            rdata_nxt[`QCSDC_MODE_DLY_HI:`QCSDC_MODE_DLY_LO] = gapDelay_r;
         end else if (regHit(address, `QCSDC_OFF_STAT)) begin
            rdata_nxt[`QCSDC_STAT_EMPTY] = empty_r;
            rdata_nxt[`QCSDC_STAT_SEL] = selN_r;
            rdata_nxt[`QCSDC_STAT_BUSY] = (state_r != QCSDC_IDLE);
            rdata_nxt[`QCSDC_STAT_FINAL] = finalReq_r;
         end
      end
      if (wrCommit && regHit(address, `QCSDC_OFF_MODE)) begin
         holdMode_nxt = writedata[`QCSDC_MODE_HOLD_HI:`QCSDC_MODE_HOLD_LO];
         gapDelay_nxt = writedata[`QCSDC_MODE_DLY_HI:`QCSDC_MODE_DLY_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
         holdMode_r <= `QCSDC_RST_HOLD;
         gapDelay_r <= `QCSDC_RST_DLY;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         holdMode_r <= holdMode_nxt;
         gapDelay_r <= gapDelay_nxt;
      end
   end

   // link clock synchroniser, edges found on the second and third stage
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= linkClk;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // select and shift sequencing
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      bitCnt_nxt = bitCnt_r;
      gapCnt_nxt = gapCnt_r;
      selN_nxt = selN_r;
      sck_nxt = 1'b0;
      dout_nxt = dout_r;
      loadNow = 1'b0;
      finalClr = 1'b0;
      empty_nxt = toBuf.ready; // R1
      case (state_r)
         QCSDC_IDLE: begin
            if (fromBuf.valid) begin
               loadNow = 1'b1;
               selN_nxt = 1'b0; // R3
            end
         end
         QCSDC_SHIFT: begin
            // clock follows link edges only, so a word loaded mid-high gives no runt rise
            sck_nxt = linkRise ? 1'b1 : (linkFall ? 1'b0 : sck_r);
            if (linkRise) begin
               bitCnt_nxt = CW'(bitCnt_r + 1'b1);
            end
            if (linkFall && bitCnt_r == CW'(WIDTH)) begin
               sck_nxt = 1'b0;
               gapCnt_nxt = '0;
               state_nxt = QCSDC_GAP;
            end else if (linkFall && bitCnt_r != '0) begin
               // a fall before the first rise must not drop the msb
               shift_nxt = {shift_r[WIDTH-2:0], 1'b0};
               dout_nxt = shift_r[WIDTH-2];
            end
         end
         QCSDC_GAP: begin
            if (gapCnt_r != gapDelay_r) begin // R9
               if (linkRise) begin
                  gapCnt_nxt = gapCnt_r + 8'h01;
               end
            end else if (holdMode_r == `QCSDC_HOLD_EACH) begin
               selN_nxt = 1'b1; // R8
               finalClr = !fromBuf.valid;
               state_nxt = QCSDC_DESEL;
            end else if (fromBuf.valid) begin
               loadNow = 1'b1; // R2 R7
            end else if (holdMode_r == `QCSDC_HOLD_KEEP && !finalReq_r) begin
               state_nxt = QCSDC_HOLDSEL; // R4
            end else begin
               selN_nxt = 1'b1; // R10
               finalClr = 1'b1;
               state_nxt = QCSDC_DESEL;
            end
         end
         QCSDC_HOLDSEL: begin
            if (fromBuf.valid) begin
               loadNow = 1'b1; // R4
            end else if (finalReq_r) begin
               selN_nxt = 1'b1; // R4 R5
               finalClr = 1'b1;
               state_nxt = QCSDC_DESEL;
            end
         end
         QCSDC_DESEL: begin
            // select stays high until the next link rise
            if (linkRise) begin
               state_nxt = QCSDC_IDLE;
            end
         end
         default: begin
            selN_nxt = 1'b1;
            state_nxt = QCSDC_IDLE;
         end
      endcase
      if (loadNow) begin
         shift_nxt = fromBuf.data;
         dout_nxt = fromBuf.data[WIDTH-1];
         bitCnt_nxt = '0;
         state_nxt = QCSDC_SHIFT;
      end
      // a final command arriving with a clear wins
      finalReq_nxt = finalReq_r && !finalClr;
      if (wrCommit && regHit(address, `QCSDC_OFF_CTRL) && writedata[`QCSDC_CTRL_FINAL]) begin
         finalReq_nxt = 1'b1; // R5
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= QCSDC_IDLE;
         shift_r <= '0;
         bitCnt_r <= '0;
         gapCnt_r <= '0;
         selN_r <= 1'b1;
         sck_r <= 1'b0;
         dout_r <= 1'b0;
         finalReq_r <= 1'b0;
         empty_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         bitCnt_r <= bitCnt_nxt;
         gapCnt_r <= gapCnt_nxt;
         selN_r <= selN_nxt;
         sck_r <= sck_nxt;
         dout_r <= dout_nxt;
         finalReq_r <= finalReq_nxt;
         empty_r <= empty_nxt; // R6
      end
   end

   assign readdata = rdata_r;
   assign waitrequest = wait_r;
   assign serialFlashSelectN = selN_r;
   assign flashClk = sck_r;
   assign flashDataOut = dout_r;
   assign holdingEmptyFlag = empty_r;
endmodule : qcsdc_top

// >>> sim/qcsdc_top_asserts.sv
// qcsdc_top_asserts: port-level checks for the select control.
// assumes a bind onto qcsdc_top and a single clock domain.
`timescale 1ns/10ps
module qcsdc_top_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // link and pins
   input wire logic linkClk,
   input wire logic serialFlashSelectN,
   input wire logic flashClk,
   input wire logic flashDataOut,
   input wire logic holdingEmptyFlag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence sReq;
      (read || write) && waitrequest && address != 4'h8;
   endsequence
   sequence sLoad;
      $fell(serialFlashSelectN);
   endsequence
   a_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
      else $error("answer without a request");
   a_answer_bound: assert property (sReq |-> ##[1:2] !waitrequest)
      else $error("request not answered in time");
   a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   a_reset_idle: assert property ($fell(srst) |-> serialFlashSelectN && holdingEmptyFlag)
      else $error("pins not idle after reset");
   a_clk_selected: assert property ($rose(flashClk) |-> !serialFlashSelectN)
      else $error("flash clock while deselected");
   a_clk_low_idle: assert property (serialFlashSelectN && $past(serialFlashSelectN)
      |-> !flashClk) else $error("flash clock runs while idle");
   a_empty_on_load: assert property (sLoad |-> ##[0:2] holdingEmptyFlag)
      else $error("no holding space after load");
   a_data_steady: assert property (flashClk && $past(flashClk) |-> $stable(flashDataOut))
      else $error("serial data moved while flash clock high");
endmodule : qcsdc_top_asserts

bind qcsdc_top qcsdc_top_asserts u_chk (.clk(clk), .srst(srst), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .linkClk(linkClk), .serialFlashSelectN(serialFlashSelectN),
   .flashClk(flashClk), .flashDataOut(flashDataOut), .holdingEmptyFlag(holdingEmptyFlag));

// >>> sim/qcsdc_flash_model.sv
// qcsdc_flash_model: serial flash that only listens on the select, clock and data lines.
// assumes data is steady at each flash clock rise.
`timescale 1ns/10ps
module qcsdc_flash_model (
   // flash pins
   input wire logic serialFlashSelectN,
   input wire logic flashClk,
   input wire logic flashDataOut,
   // observed traffic
   output logic [15:0] rxBits,
   output int rxCount,
   output int selFalls
);
   initial begin
      rxBits = 16'h0;
      rxCount = 0;
      selFalls = 0;
   end
   // every fall is a new selection, so extra releases show up here
   always @(negedge serialFlashSelectN) selFalls <= selFalls + 1;
   always @(posedge flashClk) begin
      if (!serialFlashSelectN) begin
         rxBits <= {rxBits[14:0], flashDataOut};
         rxCount <= rxCount + 1;
      end
   end
endmodule : qcsdc_flash_model

// >>> sim/qcsdc_top_tb.sv
// qcsdc_top_tb: bus-driven checks of select hold modes.
// assumes the flash model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module qcsdc_top_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic linkClk = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, rd;
   logic waitrequest, selN, fClk, fData, emptyFlag;
   logic [15:0] rxBits;
   int rxCount, selFalls, base, n, rx0;
   int numErrors = 0;
   int checksDone = 0;
   always #5 clk = ~clk;
   always #40 linkClk = ~linkClk;
   qcsdc_top DUT (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .linkClk(linkClk), .serialFlashSelectN(selN), .flashClk(fClk),
      .flashDataOut(fData), .holdingEmptyFlag(emptyFlag));
   qcsdc_flash_model u_flash (.serialFlashSelectN(selN), .flashClk(fClk),
      .flashDataOut(fData), .rxBits(rxBits), .rxCount(rxCount), .selFalls(selFalls));
   task results;
      $display("errors %0d checks %0d", numErrors, checksDone);
      if (numErrors == 0 && checksDone > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task check(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // request held until waitrequest is sampled low; a full buffer stalls here
   task busCycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
         k++;
         if (k > 3000) begin
            numErrors++;
            $display("[FAIL] %0t bus answer timeout", $time);
            results;
         end
         @(posedge clk);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : busCycle
   // waits for the bit count, then for the gap and release to settle
   task waitBits(input int target);
      int k;
      k = 0;
      while (rxCount < target) begin
         k++;
         if (k > 3000) begin
            numErrors++;
            $display("[FAIL] %0t flash bit timeout", $time);
            results;
         end
         @(posedge clk);
      end
      repeat (40) @(posedge clk);
   endtask : waitBits
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      busCycle(1'b0, 4'h4, 32'h0);
      check(rd, 32'h0);
      busCycle(1'b1, 4'h1, 32'hFF);
      busCycle(1'b0, 4'h1, 32'h0);
      check(rd, 32'h0);
      busCycle(1'b0, 4'hC, 32'h0);
      check({28'h0, rd[3:0]}, 32'h3);
      // mode 2: a release after every word
      busCycle(1'b1, 4'h4, 32'h0202);
      base = selFalls;
      // bit count taken before any word, since shifting starts during the next write
      rx0 = rxCount;
      busCycle(1'b1, 4'h8, 32'hA5);
      for (n = 0; n < 100 && emptyFlag !== 1'b1; n++) @(posedge clk);
      check({31'h0, emptyFlag}, 32'h1);
      busCycle(1'b1, 4'h8, 32'h3C);
      waitBits(rx0 + 16);
      check({16'h0, rxBits}, 32'hA53C);
      check(32'(selFalls - base), 32'h2);
      // mode 0, zero gap: three words, the last two wait in the buffer
      busCycle(1'b1, 4'h4, 32'h0);
      base = selFalls;
      rx0 = rxCount;
      busCycle(1'b1, 4'h8, 32'h81);
      busCycle(1'b1, 4'h8, 32'h7E);
      busCycle(1'b1, 4'h8, 32'hC3);
      waitBits(rx0 + 24);
      check({16'h0, rxBits}, 32'h7EC3);
      check(32'(selFalls - base), 32'h1);
      check({31'h0, selN}, 32'h1);
      // mode 1: held low with no new word until the final command
      busCycle(1'b1, 4'h4, 32'h1);
      base = selFalls;
      rx0 = rxCount;
      busCycle(1'b1, 4'h8, 32'h5A);
      waitBits(rx0 + 8);
      repeat (100) @(posedge clk);
      check({31'h0, selN}, 32'h0);
      busCycle(1'b1, 4'h0, 32'h1);
      for (n = 0; n < 200 && selN !== 1'b1; n++) @(posedge clk);
      check({31'h0, selN}, 32'h1);
      check({24'h0, rxBits[7:0]}, 32'h5A);
      check(32'(selFalls - base), 32'h1);
      results;
   end
endmodule : qcsdc_top_tb
